// File: pkg/sfc_cfg.svh
// register map, reset values, field positions and timing figures
// of the synthesizer frequency control block; definitions only
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH

// register addresses on the serial register port
`define SFC_ADDR_AFC_LIMIT 7'h2A
`define SFC_ADDR_AFC_CORR 7'h2B
`define SFC_ADDR_RATE_HI 7'h6E
`define SFC_ADDR_RATE_LO 7'h6F
`define SFC_ADDR_MOD2 7'h71
`define SFC_ADDR_DEV 7'h72
`define SFC_ADDR_OFS_LO 7'h73
`define SFC_ADDR_OFS_HI 7'h74
`define SFC_ADDR_HOP_CH 7'h79
`define SFC_ADDR_HOP_STEP 7'h7A

// power-on values
`define SFC_RST_RATE_HI 8'h0A
`define SFC_RST_RATE_LO 8'h3D
`define SFC_RST_MOD2 8'h00
`define SFC_RST_DEV 8'h20
`define SFC_RST_OFS 8'h00
`define SFC_RST_HOP 8'h00
`define SFC_RST_AFC_LIMIT 8'h00

// field positions and codes
`define SFC_DEV_MSB_BIT 2
`define SFC_DTMOD_LSB 4
`define SFC_DTMOD_FIFO 2'h2
`define SFC_OFS_HI_MASK 8'h03
`define SFC_BAND_MAX 5'h17
`define SFC_BAND_BASE 6'h18
`define SFC_FRAC_MODULUS 32'h0000FA00
`define SFC_HOP_FRAC_SHIFT 6
`define SFC_LIMIT_SHIFT 2
`define SFC_LIMIT_MAX 8'h1F
`define SFC_AFC_CLAMP 12'sh07F
`define SFC_AFC_MEAS_BITS 4'h2

// timing
`define SFC_TUNE_TIME_NS 200000
`define SFC_CLK_PERIOD_NS 10
`define SFC_RATE_REF_NS 1000
`define SFC_RATE_BASE_BITS 16
`define SFC_RATE_SCALE_BITS 5

`endif

// File: pkg/sfc_pkg.sv
// types shared by the frequency control core and its rate generator
// assumes nothing beyond a SystemVerilog compiler
package sfc_pkg;

  // operating state of the synthesizer sequencer
  typedef enum logic [2:0] {
    SFC_IDLE,
    SFC_TX,
    SFC_RX,
    SFC_RETUNE
  } sfc_state_t;

  // whole state of the core
  typedef struct packed {
    logic [7:0] rate_hi;
    logic [7:0] rate_lo;
    logic [7:0] mod2;
    logic [7:0] dev;
    logic [7:0] ofs_lo;
    logic [7:0] ofs_hi;
    logic [7:0] hop_ch;
    logic [7:0] hop_step;
    logic [7:0] afc_limit;
    logic [7:0] app_ch;
    logic [7:0] app_step;
    logic hop_pend;
    sfc_state_t fsm;
    sfc_state_t ret_fsm;
    logic [15:0] timer;
    logic signed [9:0] afc;
    logic afc_frozen;
    logic afc_settle;
    logic [3:0] afc_bits;
    logic [7:0] rdata;
    logic [31:0] divide;
    logic [9:0] lo_ofs;
  } sfc_core_t;

  // whole state of the rate generator
  typedef struct packed {
    logic [7:0] div;
    logic ref_tick;
    logic [20:0] acc;
    logic bit_tick;
  } sfc_rate_state_t;

endpackage : sfc_pkg

// File: pkg/sfc_rate_if.sv
// carrier between the core and its transmit rate generator
// both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface sfc_rate_if;
  logic [15:0] txdr;
  logic scale;
  logic run;
  logic bit_tick;
  modport ctrl (output txdr, output scale, output run, input bit_tick);
  modport gen (input txdr, input scale, input run, output bit_tick);
endinterface : sfc_rate_if
`default_nettype wire

// File: core/sfc_rate_gen.sv
// transmit bit-rate generator: phase accumulator on a 1 MHz enable
// assumes the core clock and the interface run on one clock
`timescale 1ns/1ps
`default_nettype none
`include "sfc_cfg.svh"
module sfc_rate_gen
  import sfc_pkg::*;
#(
  parameter int unsigned REF_DIV = `SFC_RATE_REF_NS / `SFC_CLK_PERIOD_NS
) (
  input wire logic clk,     // core clock
  input wire logic srst,    // synchronous reset, high
  sfc_rate_if.gen rate      // rate word in, bit tick out
);

  sfc_rate_state_t s;
  sfc_rate_state_t next_s;
  logic [21:0] sum;

  // 1 MHz enable, then accumulate the rate word; the carry is a bit time
  always_comb begin
    next_s = s;
    next_s.ref_tick = 1'b0;
    next_s.bit_tick = 1'b0;
    sum = {1'b0, s.acc} + {6'h00, rate.txdr};
    if (s.div == 8'(REF_DIV - 1)) begin
      next_s.div = 8'h00;
      next_s.ref_tick = 1'b1;
    end else begin
      next_s.div = s.div + 8'h01;
    end
    // idle outside transmit so receive never depends on the rate word
    if (!rate.run) begin
      next_s.acc = 21'h000000;
    end else if (s.ref_tick) begin
      if (rate.scale) begin
        next_s.acc = sum[20:0];
        next_s.bit_tick = sum[`SFC_RATE_BASE_BITS + `SFC_RATE_SCALE_BITS];
      end else begin
        next_s.acc = {5'h00, sum[`SFC_RATE_BASE_BITS-1:0]};
        next_s.bit_tick = sum[`SFC_RATE_BASE_BITS];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rate.bit_tick = s.bit_tick;

  // bit ticks only follow a reference tick while transmitting
  rate_tick_source_a: assert property (@(posedge clk) disable iff (srst)
    s.bit_tick |-> $past(s.ref_tick) && $past(rate.run))
    else $error("bit tick without reference tick in transmit");

  rate_idle_quiet_a: assert property (@(posedge clk) disable iff (srst)
    (!rate.run)[*2] |-> !s.bit_tick && s.acc == 21'h000000)
    else $error("rate generator active outside transmit");

endmodule : sfc_rate_gen
`default_nettype wire

// File: core/sfc_top.sv
// synthesizer frequency control: hop channels, deviation, offset, AFC,
// transmit rate. Registers come over the decoded serial register port;
// modem and sequencer signals arrive on the same clock.
//
// Summary of operation
// - carrier = nominal + step x channel x 10 kHz
// - hop write in TX/RX retunes, then returns
// - FIFO TX packet finishes on old frequency
// - deviation = 9-bit value x 625 Hz
// - deviation top bit from modulation control bit 2
// - signed manual offset, 156.25 Hz x (hb+1) units
// - manual offset unless receiving with AFC on
// - preamble detection freezes AFC for the packet
// - multi-packet receive resets AFC per packet
// - AFC pull-in limited to limiter x 625 Hz x (hb+1)
// - AFC gain halves feedback per gain step
// - measure two bits, correct, then settle
// - cycle field sets settle time, zero stops correction
// - AFC correction readable, 156.25 Hz x (hb+1) units
// - bit rate = word x 1 MHz / 2^(16+5 scale)
// - rate word used in transmit only
// - high band bit removes output divide-by-two
// - divide ratio = band + 24 + fraction / 64000
`timescale 1ns/1ps
`default_nettype none
`include "sfc_cfg.svh"
module sfc_top
  import sfc_pkg::*;
#(
  parameter int unsigned TUNE_CYCLES = `SFC_TUNE_TIME_NS / `SFC_CLK_PERIOD_NS
) (
  input wire logic CLOCK_IN,                    // 100 MHz reference clock
  input wire logic SRST_IN,                     // synchronous reset, high
  input wire logic [6:0] REG_ADDR_IN,           // register address
  input wire logic [7:0] REG_WDATA_IN,          // register write data
  input wire logic REG_WR_IN,                   // write strobe
  input wire logic REG_RD_IN,                   // read strobe
  output logic [7:0] REG_RDATA_OUT,             // read data, next cycle
  input wire logic HIGH_BAND_IN,                // high band select
  input wire logic [4:0] BAND_INTEGER_IN,       // integer part of divider
  input wire logic [15:0] CARRIER_FRACTION_IN,  // nominal fraction word
  input wire logic TX_RATE_SCALE_IN,            // rate scale bit
  input wire logic TX_ON_IN,                    // transmit requested
  input wire logic RX_ON_IN,                    // receive requested
  input wire logic TX_PACKET_BUSY_IN,           // FIFO packet being sent
  input wire logic AFC_ENABLE_IN,               // AFC on
  input wire logic [2:0] AFC_GEAR_IN,           // feedback gain shift
  input wire logic [2:0] AFC_CYCLE_IN,          // AFC settle length
  input wire logic RX_BIT_TICK_IN,              // receive bit strobe
  input wire logic [7:0] FREQ_ERROR_IN,         // measured error, signed
  input wire logic PREAMBLE_DET_IN,             // preamble found
  input wire logic PACKET_END_IN,               // packet finished
  input wire logic MULTI_PACKET_IN,             // stay in receive
  output logic [2:0] SYNTH_STATE_OUT,           // sequencer state
  output logic [31:0] SYNTH_DIVIDE_OUT,         // divide ratio x 64000
  output logic OUTPUT_HALVE_OUT,                // low band divide-by-two
  output logic [8:0] DEVIATION_OUT,             // peak deviation, 625 Hz
  output logic [9:0] LO_OFFSET_OUT,             // applied offset, signed
  output logic TX_BIT_TICK_OUT                  // one pulse per tx bit
);

  // ****************************************************************
  // state and decode
  // ****************************************************************
  sfc_core_t s;
  sfc_core_t next_s;
  sfc_rate_if rate_bus ();

  logic wr_hop;
  logic tx_fifo;
  logic [5:0] band_n;
  logic [21:0] hop_frac;
  logic [9:0] manual_ofs;
  logic signed [11:0] afc_step;
  logic signed [11:0] afc_sum;
  logic signed [11:0] afc_lim;

  assign wr_hop = REG_WR_IN && (REG_ADDR_IN == `SFC_ADDR_HOP_CH ||
                                REG_ADDR_IN == `SFC_ADDR_HOP_STEP);
  assign tx_fifo = (s.mod2[`SFC_DTMOD_LSB +: 2] == `SFC_DTMOD_FIFO);
  assign manual_ofs = {s.ofs_hi[1:0], s.ofs_lo};

  // band integer clamps at its top value before the fixed base is added
  assign band_n = (BAND_INTEGER_IN > `SFC_BAND_MAX) ?
                  (`SFC_BAND_MAX + `SFC_BAND_BASE) :
                  ({1'b0, BAND_INTEGER_IN} + `SFC_BAND_BASE);
  // one 10 kHz step is 64 fraction units, halved in the high band
  // operands widened first so the shift keeps the top product bits
  assign hop_frac = ((22'(s.app_step) * 22'(s.app_ch)) << `SFC_HOP_FRAC_SHIFT)
                    >> HIGH_BAND_IN;

  // AFC arithmetic: gain shift, then clamp to the limiter and 8 bits
  assign afc_step = 12'(signed'(FREQ_ERROR_IN)) >>> AFC_GEAR_IN;
  assign afc_sum = 12'(s.afc) + afc_step;
  assign afc_lim = (s.afc_limit > `SFC_LIMIT_MAX) ? `SFC_AFC_CLAMP :
                   12'({4'h0, s.afc_limit} << `SFC_LIMIT_SHIFT);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    // register writes; the offset high byte keeps only its two bits
    if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        `SFC_ADDR_AFC_LIMIT: next_s.afc_limit = REG_WDATA_IN;
        `SFC_ADDR_RATE_HI: next_s.rate_hi = REG_WDATA_IN;
        `SFC_ADDR_RATE_LO: next_s.rate_lo = REG_WDATA_IN;
        `SFC_ADDR_MOD2: next_s.mod2 = REG_WDATA_IN;
        `SFC_ADDR_DEV: next_s.dev = REG_WDATA_IN;
        `SFC_ADDR_OFS_LO: next_s.ofs_lo = REG_WDATA_IN;
        `SFC_ADDR_OFS_HI: next_s.ofs_hi = REG_WDATA_IN & `SFC_OFS_HI_MASK;
        `SFC_ADDR_HOP_CH: next_s.hop_ch = REG_WDATA_IN;
        `SFC_ADDR_HOP_STEP: next_s.hop_step = REG_WDATA_IN;
        default: next_s.rdata = s.rdata;
      endcase
    end
    // read data is registered; unmapped addresses read zero
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        `SFC_ADDR_AFC_LIMIT: next_s.rdata = s.afc_limit;
        `SFC_ADDR_AFC_CORR: next_s.rdata = s.afc[7:0];
        `SFC_ADDR_RATE_HI: next_s.rdata = s.rate_hi;
        `SFC_ADDR_RATE_LO: next_s.rdata = s.rate_lo;
        `SFC_ADDR_MOD2: next_s.rdata = s.mod2;
        `SFC_ADDR_DEV: next_s.rdata = s.dev;
        `SFC_ADDR_OFS_LO: next_s.rdata = s.ofs_lo;
        `SFC_ADDR_OFS_HI: next_s.rdata = s.ofs_hi;
        `SFC_ADDR_HOP_CH: next_s.rdata = s.hop_ch;
        `SFC_ADDR_HOP_STEP: next_s.rdata = s.hop_step;
        default: next_s.rdata = 8'h00;
      endcase
    end

    // sequencer: a hop write while active detours through retune
    case (s.fsm)
      SFC_IDLE: begin
        next_s.app_ch = next_s.hop_ch;
        next_s.app_step = next_s.hop_step;
        next_s.hop_pend = 1'b0;
        if (TX_ON_IN) begin
          next_s.fsm = SFC_TX;
        end else if (RX_ON_IN) begin
          next_s.fsm = SFC_RX;
        end
      end
      SFC_TX, SFC_RX: begin
        if ((s.fsm == SFC_TX && !TX_ON_IN) || (s.fsm == SFC_RX && !RX_ON_IN)) begin
          next_s.fsm = SFC_IDLE;
        end else if (s.fsm == SFC_TX && tx_fifo && TX_PACKET_BUSY_IN) begin
          // a FIFO packet in flight keeps its frequency
          next_s.hop_pend = s.hop_pend || wr_hop;
        end else if (wr_hop || s.hop_pend) begin
          next_s.app_ch = next_s.hop_ch;
          next_s.app_step = next_s.hop_step;
          next_s.hop_pend = 1'b0;
          next_s.ret_fsm = s.fsm;
          next_s.timer = 16'(TUNE_CYCLES - 1);
          next_s.fsm = SFC_RETUNE;
        end
      end
      SFC_RETUNE: begin
        // a further hop write restarts the settling wait
        if (wr_hop) begin
          next_s.app_ch = next_s.hop_ch;
          next_s.app_step = next_s.hop_step;
          next_s.timer = 16'(TUNE_CYCLES - 1);
        end else if (s.timer != 16'h0000) begin
          next_s.timer = s.timer - 16'h0001;
        end else if ((s.ret_fsm == SFC_TX && TX_ON_IN) ||
                     (s.ret_fsm == SFC_RX && RX_ON_IN)) begin
          next_s.fsm = s.ret_fsm;
        end else begin
          next_s.fsm = SFC_IDLE;
        end
      end
      default: next_s.fsm = SFC_IDLE;
    endcase

    // AFC loop, active only while receiving with AFC on
    if (s.fsm != SFC_RX || !AFC_ENABLE_IN) begin
      next_s.afc_frozen = 1'b0;
      next_s.afc_settle = 1'b0;
      next_s.afc_bits = 4'h0;
      if (s.fsm == SFC_IDLE) begin
        next_s.afc = 10'sh000;
      end
    end else if (PACKET_END_IN) begin
      // multi-packet: start over for the next packet
      if (MULTI_PACKET_IN) begin
        next_s.afc = 10'sh000;
        next_s.afc_frozen = 1'b0;
        next_s.afc_settle = 1'b0;
        next_s.afc_bits = 4'h0;
      end
    end else if (PREAMBLE_DET_IN || s.afc_frozen) begin
      next_s.afc_frozen = 1'b1;
    end else if (RX_BIT_TICK_IN && AFC_CYCLE_IN != 3'h0) begin
      next_s.afc_bits = s.afc_bits + 4'h1;
      if (!s.afc_settle && next_s.afc_bits == `SFC_AFC_MEAS_BITS) begin
        // two bit times measured: correct, clamped to the pull-in range
        if (afc_sum > afc_lim) begin
          next_s.afc = 10'(afc_lim);
        end else if (afc_sum < -afc_lim) begin
          next_s.afc = 10'(-afc_lim);
        end else begin
          next_s.afc = 10'(afc_sum);
        end
        next_s.afc_settle = 1'b1;
        next_s.afc_bits = 4'h0;
      end else if (s.afc_settle && next_s.afc_bits == {AFC_CYCLE_IN, 1'b0}) begin
        next_s.afc_settle = 1'b0;
        next_s.afc_bits = 4'h0;
      end
    end

    // offset source: AFC only in receive with AFC on, manual otherwise
    next_s.lo_ofs = (next_s.fsm == SFC_RX && AFC_ENABLE_IN) ?
                    next_s.afc : manual_ofs;
    // one offset unit is one fraction unit in either band
    next_s.divide = 32'(band_n) * `SFC_FRAC_MODULUS + 32'(CARRIER_FRACTION_IN)
                    + 32'(hop_frac) + 32'(signed'(s.lo_ofs));
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      s <= '0;
      s.rate_hi <= `SFC_RST_RATE_HI;
      s.rate_lo <= `SFC_RST_RATE_LO;
      s.mod2 <= `SFC_RST_MOD2;
      s.dev <= `SFC_RST_DEV;
      s.ofs_lo <= `SFC_RST_OFS;
      s.ofs_hi <= `SFC_RST_OFS;
      s.hop_ch <= `SFC_RST_HOP;
      s.hop_step <= `SFC_RST_HOP;
      s.afc_limit <= `SFC_RST_AFC_LIMIT;
      s.fsm <= SFC_IDLE;
      s.ret_fsm <= SFC_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // rate generator and outputs
  // ****************************************************************
  assign rate_bus.txdr = {s.rate_hi, s.rate_lo};
  assign rate_bus.scale = TX_RATE_SCALE_IN;
  assign rate_bus.run = (s.fsm == SFC_TX);

  sfc_rate_gen u_rate_gen (
    .clk(CLOCK_IN),
    .srst(SRST_IN),
    .rate(rate_bus)
  );

  assign REG_RDATA_OUT = s.rdata;
  assign SYNTH_STATE_OUT = s.fsm;
  assign SYNTH_DIVIDE_OUT = s.divide;
  assign OUTPUT_HALVE_OUT = !HIGH_BAND_IN;
  // deviation stays in 625 Hz units whatever the band
  assign DEVIATION_OUT = {s.mod2[`SFC_DEV_MSB_BIT], s.dev};
  assign LO_OFFSET_OUT = s.lo_ofs;
  assign TX_BIT_TICK_OUT = rate_bus.bit_tick;

  // ****************************************************************
  // checks
  // ****************************************************************
  hop_idle_apply_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (s.fsm == SFC_IDLE && REG_WR_IN && REG_ADDR_IN == `SFC_ADDR_HOP_CH)
    |=> s.app_ch == $past(REG_WDATA_IN))
    else $error("idle hop channel write not applied");

  hop_retune_entry_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (s.fsm == SFC_RX && RX_ON_IN && wr_hop)
    |=> s.fsm == SFC_RETUNE && s.ret_fsm == SFC_RX)
    else $error("hop write in receive did not retune");

  fifo_packet_hold_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (s.fsm == SFC_TX && TX_ON_IN && tx_fifo && TX_PACKET_BUSY_IN && wr_hop)
    |=> s.fsm == SFC_TX && s.hop_pend && $stable(s.app_ch))
    else $error("frequency changed inside a FIFO packet");

  deviation_byte_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (REG_WR_IN && REG_ADDR_IN == `SFC_ADDR_DEV)
    |=> DEVIATION_OUT[7:0] == $past(REG_WDATA_IN))
    else $error("deviation low byte not taken");

  tx_manual_offset_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (s.fsm == SFC_TX) |-> LO_OFFSET_OUT == $past(manual_ofs))
    else $error("transmit not using manual offset");

  afc_frozen_hold_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (s.afc_frozen && s.fsm == SFC_RX && !PACKET_END_IN) |=> $stable(s.afc))
    else $error("AFC moved after preamble");

  afc_packet_reset_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (s.fsm == SFC_RX && AFC_ENABLE_IN && PACKET_END_IN && MULTI_PACKET_IN)
    |=> s.afc == 10'sh000 && !s.afc_frozen)
    else $error("AFC not reset between packets");

  afc_pull_limit_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (s.afc != $past(s.afc) && s.fsm == SFC_RX)
    |-> 12'(s.afc) <= $past(afc_lim) && 12'(s.afc) >= -$past(afc_lim))
    else $error("AFC beyond pull-in range");

  afc_cycle_off_a: assert property (@(posedge CLOCK_IN) disable iff (SRST_IN)
    (s.fsm == SFC_RX && AFC_CYCLE_IN == 3'h0 && !PACKET_END_IN)[*2]
    |-> $stable(s.afc))
    else $error("AFC corrected with zero cycle field");

endmodule : sfc_top
`default_nettype wire

// File: verification/sfc_host.sv
// host controller model: drives the register port one access at a time
// assumes the bench calls its tasks from one process, core clock shared
`timescale 1ns/1ps
`default_nettype none
module sfc_host (
  input wire logic clk,          // core clock
  input wire logic [7:0] rdata,  // read data from the block
  output var logic [6:0] addr,   // register address
  output var logic [7:0] wdata,  // write data
  output var logic wr,           // write strobe
  output var logic rd            // read strobe
);
  // idle port: strobes low, address and data parked at junk values
  initial begin
    addr = 7'h55;
    wdata = 8'hAA;
    wr = 1'b0;
    rd = 1'b0;
  end
  // one write: request held across exactly one rising edge
  task automatic wr8(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a; // released lines never keep their last value
    wdata = ~d;
  endtask : wr8
  // one read: data is registered, so it is taken a cycle later
  task automatic rd8(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    @(negedge clk);
    d = rdata;
  endtask : rd8
  // slow rates need the finer scale; above 100 kbps the modulation tuning
  // register would also go to C0h, which lives outside this block
  task automatic pick_scale(input int bps, output logic s);
    s = (bps < 30000);
  endtask : pick_scale
  // preamble length the host programs; AFC needs the longer one
  function automatic int preamble_bits(input logic afc_on);
    return afc_on ? 40 : 32;
  endfunction : preamble_bits
endmodule : sfc_host
`default_nettype wire

// File: verification/test_synth_frequency_control.sv
// bench for the frequency control block: registers, hops, offset, AFC, rate
// assumes sfc_host drives the register port; other inputs driven here
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_synth_frequency_control;
  import sfc_pkg::*;
  localparam int TUNE = 4;
  logic clk = 1'b0, srst = 1'b1, hb = 1'b0, scale = 1'b0, tx_on = 1'b0, rx_on = 1'b0;
  logic busy = 1'b0, afc_en = 1'b0, rtick = 1'b0, pre = 1'b0, pend = 1'b0, multi = 1'b0;
  logic [4:0] band = 5'h03;
  logic [15:0] frac = 16'h03E8;
  logic [2:0] gear = 3'h1, cyc = 3'h1, state;
  logic [7:0] ferr = 8'h20, rdata, wdata, rv;
  logic [6:0] addr;
  logic wr, rd, halve, ttick;
  logic [31:0] divide;
  logic [8:0] dev;
  logic [9:0] lo;
  int n_fail = 0, check_count = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  sfc_host sfc_host_i (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  // short retune wait keeps the hop scenarios quick
  sfc_top #(.TUNE_CYCLES(TUNE)) sfc_top_i (.CLOCK_IN(clk), .SRST_IN(srst), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .HIGH_BAND_IN(hb), .BAND_INTEGER_IN(band), .CARRIER_FRACTION_IN(frac),
    .TX_RATE_SCALE_IN(scale), .TX_ON_IN(tx_on), .RX_ON_IN(rx_on), .TX_PACKET_BUSY_IN(busy),
    .AFC_ENABLE_IN(afc_en), .AFC_GEAR_IN(gear), .AFC_CYCLE_IN(cyc), .RX_BIT_TICK_IN(rtick),
    .FREQ_ERROR_IN(ferr), .PREAMBLE_DET_IN(pre), .PACKET_END_IN(pend), .MULTI_PACKET_IN(multi),
    .SYNTH_STATE_OUT(state), .SYNTH_DIVIDE_OUT(divide), .OUTPUT_HALVE_OUT(halve),
    .DEVIATION_OUT(dev), .LO_OFFSET_OUT(lo), .TX_BIT_TICK_OUT(ttick));
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc_n
  // expected divide in fraction units; one hop unit is 64 in low band only
  function automatic logic [31:0] div_exp(input int b, input int s, input int c, input int o);
    return 32'((b > 23 ? 23 : b) * 64000 + 1536000 + frac + s * c * 64 + o);
  endfunction : div_exp
  task automatic complete_run;
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // register port: power-on table, unmapped, narrow and read-only places
  task automatic t_regs;
    logic [6:0] a [10] = '{7'h6E, 7'h6F, 7'h71, 7'h72, 7'h73, 7'h74, 7'h79, 7'h7A, 7'h2A, 7'h10};
    logic [7:0] e [10] = '{8'h0A, 8'h3D, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++) begin
      sfc_host_i.rd8(a[i], rv);
      `CHK(rv, e[i])
    end
    sfc_host_i.wr8(7'h74, 8'hFF);
    sfc_host_i.rd8(7'h74, rv);
    `CHK(rv, 8'h03)
    sfc_host_i.wr8(7'h2B, 8'h55);
    sfc_host_i.rd8(7'h2B, rv);
    `CHK(rv, 8'h00)
    sfc_host_i.wr8(7'h74, 8'h00);
  endtask : t_regs
  // hop arithmetic in idle, band clamp, band halving, signed manual offset
  task automatic t_freq;
    sfc_host_i.wr8(7'h7A, 8'h05);
    sfc_host_i.wr8(7'h79, 8'h07);
    cyc_n(2);
    `CHK(divide, div_exp(3, 5, 7, 0))
    `CHK(halve, 1'b1)
    hb = 1'b1;
    cyc_n(1);
    `CHK(halve, 1'b0)
    // high band: one 10 kHz step is 32 fraction units, not 64
    `CHK(divide, div_exp(3, 5, 7, 0) - 32'd1120)
    hb = 1'b0;
    band = 5'h1E;
    sfc_host_i.wr8(7'h79, 8'h09);
    sfc_host_i.wr8(7'h74, 8'h03);
    sfc_host_i.wr8(7'h73, 8'h60);
    cyc_n(2);
    `CHK(lo, 10'h360)
    `CHK(divide, div_exp(30, 5, 9, -160))
    sfc_host_i.wr8(7'h74, 8'h00);
    sfc_host_i.wr8(7'h73, 8'h00);
    band = 5'h03;
  endtask : t_freq
  // deviation top bit comes from bit 2 only of the modulation register
  task automatic t_dev;
    sfc_host_i.wr8(7'h71, 8'h04);
    sfc_host_i.wr8(7'h72, 8'h55);
    cyc_n(1);
    `CHK(dev, 9'h155)
    sfc_host_i.wr8(7'h71, 8'hFB);
    cyc_n(1);
    `CHK(dev, 9'h055)
    sfc_host_i.wr8(7'h71, 8'h00);
  endtask : t_dev
  // retune from RX, then a FIFO transmit packet that defers the hop
  task automatic t_hop;
    int n = 0;
    rx_on = 1'b1;
    cyc_n(2);
    sfc_host_i.wr8(7'h79, 8'h02);
    `CHK(state, 3'h3)
    while (state === 3'h3 && n < 50) begin
      n++;
      cyc_n(1);
    end
    if (n == 50) begin
      n_fail++;
      complete_run();
    end
    `CHK(state, 3'h2)
    `CHK(n >= TUNE - 1 && n <= TUNE + 1, 1'b1)
    `CHK(divide, div_exp(3, 5, 2, 0))
    rx_on = 1'b0;
    sfc_host_i.wr8(7'h71, 8'h20);
    busy = 1'b1;
    tx_on = 1'b1;
    cyc_n(2);
    sfc_host_i.wr8(7'h79, 8'h04);
    cyc_n(TUNE + 2);
    `CHK(state, 3'h1)
    `CHK(divide, div_exp(3, 5, 2, 0))
    busy = 1'b0;
    cyc_n(TUNE + 4);
    `CHK(state, 3'h1)
    `CHK(divide, div_exp(3, 5, 4, 0))
    tx_on = 1'b0;
    sfc_host_i.wr8(7'h71, 8'h00);
  endtask : t_hop
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk);
      rtick = 1'b1;
      @(negedge clk);
      rtick = 1'b0;
    end
    cyc_n(2);
  endtask : tick
  // AFC: halved feedback, 4-bit cycle, clamp, freeze, per-packet reset, off
  task automatic t_afc;
    sfc_host_i.wr8(7'h2A, 8'h10);
    afc_en = 1'b1;
    rx_on = 1'b1;
    cyc_n(2);
    tick(2);
    `CHK(lo, 10'h010)
    tick(4);
    `CHK(lo, 10'h020)
    sfc_host_i.rd8(7'h2B, rv);
    `CHK(rv, 8'h20)
    tick(sfc_host_i.preamble_bits(1'b1) - 6);
    `CHK(lo, 10'h040)
    ferr = 8'hE0;
    pre = 1'b1;
    cyc_n(1);
    pre = 1'b0;
    tick(8);
    `CHK(lo, 10'h040)
    multi = 1'b1;
    pend = 1'b1;
    cyc_n(1);
    pend = 1'b0;
    cyc_n(2);
    `CHK(lo, 10'h000)
    cyc = 3'h0;
    tick(8);
    `CHK(lo, 10'h000)
    cyc = 3'h1;
    afc_en = 1'b0;
    rx_on = 1'b0;
    multi = 1'b0;
  endtask : t_afc
  task automatic count_ticks(input int cycles, output int n);
    n = 0;
    repeat (cycles) begin
      @(negedge clk);
      if (ttick !== 1'b0) n++; // an unknown tick counts, so it cannot pass unseen
    end
  endtask : count_ticks
  // bit rate in both scales; the rate word must not tick in receive
  task automatic t_rate;
    int n;
    sfc_host_i.pick_scale(60000, scale);
    sfc_host_i.wr8(7'h6E, 8'h40);
    sfc_host_i.wr8(7'h6F, 8'h00);
    tx_on = 1'b1;
    count_ticks(4000, n);
    `CHK(n >= 9 && n <= 10, 1'b1)
    tx_on = 1'b0;
    rx_on = 1'b1;
    count_ticks(2000, n);
    `CHK(n, 0)
    rx_on = 1'b0;
    sfc_host_i.pick_scale(1000, scale);
    sfc_host_i.wr8(7'h6E, 8'hFF);
    sfc_host_i.wr8(7'h6F, 8'hFF);
    tx_on = 1'b1;
    count_ticks(7000, n);
    `CHK(n >= 2 && n <= 3, 1'b1)
    tx_on = 1'b0;
  endtask : t_rate
  // reset for five cycles, then every scenario in turn
  initial begin
    repeat (5) @(negedge clk);
    srst = 1'b0;
    `CHK(dev, 9'h020)
    t_regs();
    t_freq();
    t_dev();
    t_hop();
    t_afc();
    t_rate();
    complete_run();
  end
endmodule : test_synth_frequency_control
`default_nettype wire
